// ===== ddg_ctrl_model.sv
/*
 * Behavioural model of the memory controller that drives the command side.
 * Assumes the bench calls its tasks just after a rising edge of sys_clk.
 */
`timescale 1ns/1ns
`default_nettype none

module ddg_ctrl_model (
	input wire logic sys_clk,
	input wire logic ctrl_sample,
	output logic cs_n,
	output logic cke,
	output logic cmd_mrs,
	output logic [2:0] mr_sel,
	output logic [13:0] mr_addr,
	output logic cmd_sre,
	output logic cmd_srx,
	output logic init_done
);
	// Idle bus is deselect with the clock enabled and no command strobe active.
	initial begin
		cs_n = 1'b1;
		cke = 1'b1;
		cmd_mrs = 1'b0;
		mr_sel = 3'h0;
		mr_addr = 14'h0000;
		cmd_sre = 1'b0;
		cmd_srx = 1'b0;
		init_done = 1'b0;
	end

	////////////////////////////////////////////////////////////////////////////////
	// One command held through its sampling edge, waiting for the live phase in 2N.
	// The address lines show the inverse afterwards so no stale value looks valid.
	task automatic cmd(input logic [2:0] kind, input logic [2:0] sel, input logic [13:0] val);
		int n;
		begin
			for (n = 0; n < 4 && ctrl_sample !== 1'b1; n++) begin
				@(posedge sys_clk) #1;
			end
			cs_n = 1'b0;
			cmd_mrs = kind[0];
			cmd_sre = kind[1];
			cmd_srx = kind[2];
			mr_sel = sel;
			mr_addr = val;
			@(posedge sys_clk) #1;
			cs_n = 1'b1;
			cmd_mrs = 1'b0;
			cmd_sre = 1'b0;
			cmd_srx = 1'b0;
			mr_sel = ~sel;
			mr_addr = ~val;
		end
	endtask

	// CKE low for a clock, then high with the chosen chip select held one clock.
	// One clock low is 20 ns, inside the 12 ns to exit-time window; the clock never stops.
	task automatic cke_edge(input logic cs_val);
		begin
			cke = 1'b0;
			@(posedge sys_clk) #1;
			cke = 1'b1;
			cs_n = cs_val;
			@(posedge sys_clk) #1;
			cs_n = 1'b1;
		end
	endtask

	// Sync pulse two clocks after the gear command, then deselect only.
	task automatic sync_pulse;
		begin
			@(posedge sys_clk) #1;
			cs_n = 1'b0;
			@(posedge sys_clk) #1;
			cs_n = 1'b1;
		end
	endtask

	// Initialization flag, raised once the power-up sequence is over.
	task automatic set_init(input logic v);
		init_done = v;
	endtask
endmodule // ddg_ctrl_model

`default_nettype wire

// ===== ddg_mode_ctrl.sv
/*
 * Deep power saving mode and gear-down control of the DRAM command interface.
 * Assumes a command decoder in front that turns each chip-selected command
 * into one-cycle pulses, all inputs synchronous to sys_clk.
 */
// What this block does
// - In saving mode, all commands are ignored except mode exit and reset.
// - After the disable delay, only chip select, CKE and reset are watched.
// - Chip select low at CKE rising edge starts exit; high keeps mode.
// - Leaving the saving mode clears the mode bit of register four.
// - Default 1N; 2N sampling only after gear command and then sync pulse.
`timescale 1ns/1ns
`default_nettype none

module ddg_mode_ctrl
	import ddg_pkg::*;
#(
	parameter int MPED_CYC = T_MPED_CYC,
	parameter int XMP_CYC = T_XMP_CYC,
	parameter int XMPDLL_CYC = T_XMPDLL_CYC,
	parameter int GEAR_CYC = T_CMD_GEAR_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic cs_n,
	input wire logic cke,
	input wire logic cmd_mrs,
	input wire logic [2:0] mr_sel,
	input wire logic [13:0] mr_addr,
	input wire logic cmd_sre,
	input wire logic cmd_srx,
	input wire logic init_done,
	output logic deep_power_saving_mode,
	output logic cmd_path_on,
	output logic exit_busy,
	output logic dll_cmd_ok,
	output logic gear_2n,
	output logic ctrl_sample,
	output logic cmd_ignored,
	output logic mr3_gear,
	output logic mr4_save
);
	////////////////////////////////////////////////////////////////////////
	// Types and state.

	typedef enum logic [4:0] {
		ST_NORM = 5'b0_0001,
		ST_ENTRY = 5'b0_0010,
		ST_HOLD = 5'b0_0100,
		ST_EXIT = 5'b0_1000,
		ST_SREF = 5'b1_0000
	} ddg_mode_type;

	typedef enum logic [3:0] {
		G_1N = 4'b0001,
		G_WSYNC = 4'b0010,
		G_WAIT = 4'b0100,
		G_2N = 4'b1000
	} ddg_gear_type;

	typedef struct packed {
		ddg_mode_type mode;
		ddg_gear_type gear;
		logic cke_prev;
		logic phase;
		logic srx_window;
		logic ignored;
		logic mr3_gear;
		logic mr4_save;
		logic dll_ok;
	} ddg_state_type;

	ddg_state_type st_r;
	ddg_state_type st_nxt;

	logic tmr_load;
	logic [TIMER_W-1:0] tmr_val;
	logic [TIMER_W-1:0] tmr_remain;
	logic tmr_done;
	logic cke_rise;
	logic cmd_any;
	logic slot;

	localparam logic [TIMER_W-1:0] MPED_L = TIMER_W'(MPED_CYC);
	localparam logic [TIMER_W-1:0] XMPDLL_L = TIMER_W'(XMPDLL_CYC);
	localparam logic [TIMER_W-1:0] DLL_L = TIMER_W'(XMPDLL_CYC - XMP_CYC);
	localparam logic [TIMER_W-1:0] GEAR_L = TIMER_W'(GEAR_CYC);

	// The timer cannot serve waits wider than itself or shorter than a clock.
	if (XMPDLL_CYC >= (1 << TIMER_W) || MPED_CYC < 1 || XMP_CYC < 1 ||
		GEAR_CYC < 1 || XMPDLL_CYC <= XMP_CYC) begin : g_bad_param
		$error("ddg_mode_ctrl: delay parameter out of range");
	end

	////////////////////////////////////////////////////////////////////////
	// One timer serves every wait; an entry or gear load can cut short a wait still running.

	ddg_timer #(
		.W(TIMER_W)
	) u_timer (
		.sys_clk(sys_clk),
		.rst(rst),
		.load(tmr_load),
		.load_val(tmr_val),
		.remain(tmr_remain),
		.done(tmr_done)
	);

	// The CKE edge is seen on the clock because the inputs are synchronous.
	assign cke_rise = cke && !st_r.cke_prev;
	assign cmd_any = cmd_mrs || cmd_sre || cmd_srx;
	// In 2N only the clock on the phase set by the sync pulse samples controls.
	assign slot = (st_r.gear != G_2N) || st_r.phase;

	////////////////////////////////////////////////////////////////////////
	// Next-state logic for mode, gear and mode register bits.

	always_comb begin
		st_nxt = st_r;
		tmr_load = 1'b0;
		tmr_val = '0;
		st_nxt.cke_prev = cke;
		st_nxt.phase = !st_r.phase;
		st_nxt.ignored = 1'b0;
		unique case (st_r.mode)
			ST_NORM: begin
				if (cmd_mrs && slot) begin
					if (mr_sel == MR4_SEL) begin
						st_nxt.mr4_save = mr_addr[MR4_SAVE_BIT];
						if (mr_addr[MR4_SAVE_BIT]) begin
							st_nxt.mode = ST_ENTRY;
							tmr_load = 1'b1;
							tmr_val = MPED_L;
						end
					end else if (mr_sel == MR3_SEL) begin
						// Clearing the gear bit records it but keeps 2N sampling.
						st_nxt.mr3_gear = mr_addr[MR3_GEAR_BIT];
						if (mr_addr[MR3_GEAR_BIT] && st_r.gear == G_1N &&
							(!init_done || st_r.srx_window)) begin
							st_nxt.gear = G_WSYNC;
							st_nxt.phase = 1'b0;
						end
					end
				end else if (cmd_sre && slot) begin
					st_nxt.mode = ST_SREF;
				end else if (cmd_any && !slot) begin
					st_nxt.ignored = 1'b1;
				end
				if (cmd_any && !(cmd_mrs && mr_sel == MR3_SEL)) begin
					st_nxt.srx_window = 1'b0;
				end
			end
			ST_ENTRY: begin
				st_nxt.ignored = cmd_any;
				if (tmr_done) begin
					st_nxt.mode = ST_HOLD;
				end
			end
			ST_HOLD: begin
				// Only chip select at a CKE rising edge is looked at here.
				st_nxt.ignored = cmd_any;
				if (cke_rise && !cs_n) begin
					st_nxt.mode = ST_EXIT;
					st_nxt.dll_ok = 1'b0;
					tmr_load = 1'b1;
					tmr_val = XMPDLL_L;
				end
			end
			ST_EXIT: begin
				st_nxt.ignored = cmd_any;
				st_nxt.mr4_save = 1'b0;
				if (tmr_remain <= DLL_L) begin
					st_nxt.mode = ST_NORM;
				end
			end
			ST_SREF: begin
				// Self refresh drops the gear back to 1N on its own.
				st_nxt.gear = G_1N;
				st_nxt.mr3_gear = 1'b0;
				if (cmd_srx) begin
					st_nxt.mode = ST_NORM;
					st_nxt.srx_window = 1'b1;
				end else begin
					st_nxt.ignored = cmd_mrs || cmd_sre;
				end
			end
			default: begin
				st_nxt.mode = ST_NORM;
			end
		endcase
		// The DLL flag rises when the exit wait has fully run out.
		if (st_r.mode != ST_HOLD && st_r.mode != ST_ENTRY && tmr_done) begin
			st_nxt.dll_ok = 1'b1;
		end
		// The first chip-selected clock after the gear command that is not a mode register set is the sync.
		unique case (st_r.gear)
			G_1N: begin
			end
			G_WSYNC: begin
				if (!cs_n && st_r.mode == ST_NORM && !cmd_mrs) begin
					st_nxt.gear = G_WAIT;
					st_nxt.phase = 1'b0;
					tmr_load = 1'b1;
					tmr_val = GEAR_L;
				end
			end
			G_WAIT: begin
				if (tmr_done) begin
					st_nxt.gear = G_2N;
				end
			end
			G_2N: begin
			end
			default: begin
				st_nxt.gear = G_1N;
			end
		endcase
	end

	// Reset stands for RESET# low, which also ends the saving mode.
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r <= '{mode: ST_NORM, gear: G_1N, cke_prev: 1'b0, phase: 1'b0,
				srx_window: 1'b0, ignored: 1'b0, mr3_gear: MR3_GEAR_RST,
				mr4_save: MR4_SAVE_RST, dll_ok: 1'b1};
		end else begin
			st_r <= st_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Outputs.

	assign deep_power_saving_mode = (st_r.mode == ST_HOLD) || (st_r.mode == ST_ENTRY);
	assign cmd_path_on = (st_r.mode == ST_NORM);
	assign exit_busy = (st_r.mode == ST_EXIT);
	assign dll_cmd_ok = st_r.dll_ok;
	assign gear_2n = (st_r.gear == G_2N);
	assign ctrl_sample = slot;
	assign cmd_ignored = st_r.ignored;
	assign mr3_gear = st_r.mr3_gear;
	assign mr4_save = st_r.mr4_save;

	////////////////////////////////////////////////////////////////////////
	// Checks on the mode and gear sequences.

	sequence exit_trigger_s;
		st_r.mode == ST_HOLD && cke_rise && !cs_n;
	endsequence

	sequence exit_done_s;
		exit_busy ##1 !mr4_save;
	endsequence

	stay_in_mode_a: assert property (@(posedge sys_clk) disable iff (rst)
		st_r.mode == ST_HOLD && cke_rise && cs_n |=> deep_power_saving_mode)
		else $error("saving mode left with chip select high");

	exit_start_a: assert property (@(posedge sys_clk) disable iff (rst)
		exit_trigger_s |=> exit_done_s)
		else $error("exit not started on chip select low at CKE rise");

	mode_bit_clear_a: assert property (@(posedge sys_clk) disable iff (rst)
		$fell(exit_busy) |-> !mr4_save && cmd_path_on)
		else $error("saving mode bit not cleared on exit");

	ignore_cmd_a: assert property (@(posedge sys_clk) disable iff (rst)
		deep_power_saving_mode && cmd_mrs |=> cmd_ignored && !cmd_path_on)
		else $error("command acted on in saving mode");

	cmd_path_off_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(deep_power_saving_mode) |-> !cmd_path_on [*8])
		else $error("command path open during disable delay");

	gear_default_a: assert property (@(posedge sys_clk) disable iff (rst)
		$rose(gear_2n) |-> $past(st_r.gear) == G_WAIT)
		else $error("2N entered without gear command and sync");

	gear_1n_sample_a: assert property (@(posedge sys_clk) disable iff (rst)
		!gear_2n |-> ctrl_sample)
		else $error("1N sampling skipped a clock");

	gear_2n_phase_a: assert property (@(posedge sys_clk) disable iff (rst)
		gear_2n && ctrl_sample ##1 gear_2n |-> !ctrl_sample)
		else $error("2N sampling not every other clock");
endmodule // ddg_mode_ctrl

`default_nettype wire

// ===== ddg_timer.sv
/*
 * Shared constants of the deep power saving and gear-down block, and the
 * down-counting delay timer that the mode controller uses for its waits.
 * Assumes one 50 MHz clock and an asynchronous, active-high reset.
 */
`timescale 1ns/1ns
`default_nettype none

package ddg_pkg;
	// Clock period in nanoseconds.
	localparam int T_CK_NS = 20;
	// Mode register set delay and CKE power-down command delay, in clocks.
	localparam int T_MOD_CYC = 24;
	localparam int T_CPDED_CYC = 4;
	// Command path disable delay after entering the saving mode.
	localparam int T_MPED_CYC = T_MOD_CYC + T_CPDED_CYC;
	// Exit time to commands not needing the DLL, as a least time in ns.
	localparam int T_XMP_NS = 270;
	localparam int T_XMP_CYC = (T_XMP_NS + T_CK_NS - 1) / T_CK_NS;
	// DLL lock time that adds to the exit time, in clocks.
	localparam int T_XSDLL_CYC = 768;
	localparam int T_XMPDLL_CYC = T_XMP_CYC + T_XSDLL_CYC;
	// Command gear delay after the sync pulse, in clocks.
	localparam int T_CMD_GEAR_CYC = 24;
	// Mode register numbers and bit positions.
	localparam logic [2:0] MR3_SEL = 3'h3;
	localparam logic [2:0] MR4_SEL = 3'h4;
	localparam int MR3_GEAR_BIT = 3;
	localparam int MR4_SAVE_BIT = 1;
	// Reset values of the two mode bits.
	localparam logic MR3_GEAR_RST = 1'b0;
	localparam logic MR4_SAVE_RST = 1'b0;
	// Width of the delay timer.
	localparam int TIMER_W = 12;
endpackage : ddg_pkg

////////////////////////////////////////////////////////////////////////////////

module ddg_timer
	import ddg_pkg::*;
#(
	parameter int W = TIMER_W
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic load,
	input wire logic [W-1:0] load_val,
	output logic [W-1:0] remain,
	output logic done
);
	// A counter narrower than two bits cannot hold even the shortest wait.
	if (W < 2) begin : g_bad_w
		$error("ddg_timer: counter width too small");
	end

	typedef struct packed {
		logic [W-1:0] cnt;
	} ddg_tmr_type;

	ddg_tmr_type st_r;
	ddg_tmr_type st_nxt;

	// Loading wins over counting so a new wait always restarts cleanly.
	always_comb begin
		st_nxt = st_r;
		if (load) begin
			st_nxt.cnt = load_val;
		end else if (st_r.cnt != '0) begin
			st_nxt.cnt = st_r.cnt - 1'b1;
		end
	end

	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			st_r <= '0;
		end else begin
			st_r <= st_nxt;
		end
	end

	assign remain = st_r.cnt;
	assign done = (st_r.cnt == '0);
endmodule // ddg_timer

`default_nettype wire

// ===== dram_deep_sleep_and_geardown_tb.sv
/*
 * Self-checking bench of the saving mode and gear-down controller.
 * Assumes the controller model drives every command input; timers are shortened.
 */
`timescale 1ns/1ns
`default_nettype none

module dram_deep_sleep_and_geardown_tb;
	import ddg_pkg::*;
	localparam int MPED = 4;
	localparam int XMP = 6;
	localparam int XMPDLL = 12;
	localparam int GEAR = 4;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic cs_n, cke, cmd_mrs, cmd_sre, cmd_srx, init_done;
	logic [2:0] mr_sel;
	logic [13:0] mr_addr;
	logic deep, path, busy, dll_ok, gear, samp, ign, mr3, mr4;
	logic a;
	int n_mismatch = 0;
	int comparisons = 0;

	// Free-running 50 MHz clock.
	always #10 sys_clk = ~sys_clk;

	ddg_ctrl_model i_ddg_ctrl_model (.sys_clk(sys_clk), .ctrl_sample(samp), .cs_n(cs_n),
		.cke(cke), .cmd_mrs(cmd_mrs), .mr_sel(mr_sel), .mr_addr(mr_addr), .cmd_sre(cmd_sre),
		.cmd_srx(cmd_srx), .init_done(init_done));
	ddg_mode_ctrl #(.MPED_CYC(MPED), .XMP_CYC(XMP), .XMPDLL_CYC(XMPDLL), .GEAR_CYC(GEAR))
		i_ddg_mode_ctrl (.sys_clk(sys_clk), .rst(rst), .cs_n(cs_n), .cke(cke),
		.cmd_mrs(cmd_mrs), .mr_sel(mr_sel), .mr_addr(mr_addr), .cmd_sre(cmd_sre),
		.cmd_srx(cmd_srx), .init_done(init_done), .deep_power_saving_mode(deep),
		.cmd_path_on(path), .exit_busy(busy), .dll_cmd_ok(dll_ok), .gear_2n(gear),
		.ctrl_sample(samp), .cmd_ignored(ign), .mr3_gear(mr3), .mr4_save(mr4));

	////////////////////////////////////////////////////////////////////////////////
	// Compare one bit; case inequality so an unknown never passes.
	task automatic check(input string name, input logic seen, input logic exp);
		comparisons++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("ERROR %s expected %b seen %b", name, exp, seen);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge sys_clk) #1;
	endtask

	// Verdict, printed once from here only.
	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
		if (n_mismatch == 0 && comparisons > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////////////////////
	task automatic t_reset;
		check("path", path, 1'b1);
		check("sample", samp, 1'b1);
		check("dll_ok", dll_ok, 1'b1);
		check("deep", deep, 1'b0);
		check("busy", busy, 1'b0);
		check("gear", gear, 1'b0);
		check("mr3", mr3, MR3_GEAR_RST);
		check("mr4", mr4, MR4_SAVE_RST);
		$display("test reset done");
	endtask

	// Entry, a refused command, a CKE toggle that keeps the mode, then the exit.
	task automatic t_saving;
		i_ddg_ctrl_model.cmd(3'h1, MR4_SEL, 14'h0002);
		cyc(1);
		check("deep", deep, 1'b1);
		check("path", path, 1'b0);
		check("mr4", mr4, 1'b1);
		cyc(MPED + 1);
		i_ddg_ctrl_model.cmd(3'h1, MR3_SEL, 14'h0008);
		a = 1'b0;
		repeat (3) begin
			if (ign === 1'b1)
				a = 1'b1;
			cyc(1);
		end
		check("ignored", a, 1'b1);
		check("mr3", mr3, 1'b0);
		i_ddg_ctrl_model.cke_edge(1'b1);
		cyc(2);
		check("deep", deep, 1'b1);
		check("busy", busy, 1'b0);
		i_ddg_ctrl_model.cke_edge(1'b0);
		cyc(1);
		check("busy", busy, 1'b1);
		check("deep", deep, 1'b0);
		check("dll_ok", dll_ok, 1'b0);
		check("mr4", mr4, 1'b0);
		check("path", path, 1'b0);
		cyc(XMP + 1);
		check("path", path, 1'b1);
		check("busy", busy, 1'b0);
		check("dll_ok", dll_ok, 1'b0);
		cyc(XMPDLL - XMP);
		check("dll_ok", dll_ok, 1'b1);
		$display("test saving mode done");
	endtask

	// Gear-down at init, back to 1N through self refresh, then a refused late gear.
	task automatic t_gear;
		i_ddg_ctrl_model.cmd(3'h1, MR3_SEL, 14'h0008);
		check("mr3", mr3, 1'b1);
		check("gear", gear, 1'b0);
		i_ddg_ctrl_model.sync_pulse();
		cyc(GEAR + 4);
		check("gear", gear, 1'b1);
		a = samp;
		cyc(1);
		check("alternate", samp, ~a);
		i_ddg_ctrl_model.set_init(1'b1);
		i_ddg_ctrl_model.cmd(3'h2, 3'h0, 14'h0000);
		cyc(1);
		check("gear", gear, 1'b0);
		i_ddg_ctrl_model.cmd(3'h4, 3'h0, 14'h0000);
		check("sample", samp, 1'b1);
		cyc(1);
		check("sample", samp, 1'b1);
		i_ddg_ctrl_model.cmd(3'h1, 3'h0, 14'h0000);
		// One deselect clock so chip select is not lowered in the step that raised it.
		cyc(1);
		i_ddg_ctrl_model.cmd(3'h1, MR3_SEL, 14'h0008);
		check("mr3", mr3, 1'b1);
		i_ddg_ctrl_model.sync_pulse();
		cyc(GEAR + 4);
		check("gear", gear, 1'b0);
		$display("test gear done");
	endtask

	////////////////////////////////////////////////////////////////////////////////
	// Main sequence: reset held six clocks, then the tests.
	initial begin
		repeat (6) @(posedge sys_clk);
		#1 rst = 1'b0;
		t_reset();
		t_saving();
		t_gear();
		final_report();
	end

	// Watchdog at 5000 clocks, well beyond the fewer than a hundred clocks the tests need.
	initial begin
		#100000;
		n_mismatch++;
		final_report();
	end
endmodule // dram_deep_sleep_and_geardown_tb

`default_nettype wire
